// file: rtl/ets_pkg.sv
// Shared constants and types of the exposure trigger sequencer
package ets_pkg;
   // Register byte offsets
   localparam logic [11:0] A_CTRL = 12'h000;
   localparam logic [11:0] A_EXPO = 12'h004;
   localparam logic [11:0] A_GEOM = 12'h008;
   localparam logic [11:0] A_STAT = 12'h00c;
   // Control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_FLASH    = 3;
   localparam int CTRL_GPO_SEL  = 4;
   localparam int CTRL_GPO_LVL  = 5;
   localparam int CTRL_ARM      = 8;
   localparam int CTRL_STOP     = 9;
   // Geometry and status fields
   localparam int GEOM_PIX_LSB  = 0;
   localparam int GEOM_LIN_LSB  = 16;
   localparam int STAT_ST_LSB   = 0;
   localparam int STAT_EXP      = 3;
   localparam int STAT_RD       = 4;
   localparam int STAT_FC_LSB   = 16;
   // Reset values
   localparam logic [23:0] EXPO_RST = 24'h000400;
   localparam logic [11:0] PIX_RST  = 12'h040;
   localparam logic [11:0] LIN_RST  = 12'h020;
   // Default blanking lengths in clock cycles
   localparam int unsigned LINE_GAP_DEF  = 8;
   localparam int unsigned FRAME_GAP_DEF = 16;
   // Exposure modes
   typedef enum logic [2:0] {
      M_OVL_SHUT = 3'h0,
      M_OVL_EXT  = 3'h1,
      M_NONOVL   = 3'h2,
      M_SINGLE   = 3'h3,
      M_BULB     = 3'h4
   } ets_mode_e;
   // Sequencer states, Gray coded along the usual path
   typedef enum logic [2:0] {
      S_IDLE   = 3'h0,
      S_ARMED  = 3'h1,
      S_EXPOSE = 3'h3,
      S_READ   = 3'h2,
      S_RUN    = 3'h6
   } ets_state_e;
endpackage

// file: rtl/ets_top.sv
// Exposure and readout sequencer with APB register access
// Operation
// - Shuttered overlap: wait falling edge, then loop
// - Shutter time changes, frame rate stays fixed
// - Running continuous modes ignore further triggers
// - Continuous runs until stop; rearm afterwards
// - Extended overlap: no shutter, exposure exceeds readout
// - Extended overlap holds flash sync low
// - Non-overlapped: exposure then readout, serially
// - Single frame: expose, read, back to armed
// - Bulb: expose from leading to trailing edge
// - Bulb: read at once, then rearm
// - Bulb: triggers ignored during readout
// - Line valid high on pixels, low in gaps
// - Frame valid high across active lines
// - Flash sync high during exposure when enabled
// - Flash sync usable as host-set output
// - Echo host trigger line, active low
// - External trigger acts like host trigger
//
// Chosen here: register access over APB and the register addresses.
module ets_top #(
   parameter int unsigned LINE_GAP  = ets_pkg::LINE_GAP_DEF,
   parameter int unsigned FRAME_GAP = ets_pkg::FRAME_GAP_DEF
) (
   input  wire logic        I_MCLK,
   input  wire logic        I_RST,
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [11:0] I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic      [31:0] O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   input  wire logic        I_CC1_TRIG_N,
   input  wire logic        I_EXT_TRIG_N,
   output logic             O_LINE_VALID_OUT,
   output logic             O_FRAME_VALID_OUT,
   output logic             O_FLASH_SYNC,
   output logic             O_TRIGGER_ECHO_OUT
);
   localparam logic [12:0] LGAP = 13'(LINE_GAP);
   localparam logic [31:0] FGAP = 32'(FRAME_GAP);

   ets_pkg::ets_mode_e  mode_reg;
   ets_pkg::ets_mode_e  run_mode;
   ets_pkg::ets_state_e state;
   ets_pkg::ets_state_e next_state;
   logic        flash_en;
   logic        gpo_sel;
   logic        gpo_level;
   logic [23:0] expo;
   logic [11:0] pix;
   logic [11:0] lines;
   logic        cc1_s1;
   logic        cc1_s2;
   logic        ext_s1;
   logic        ext_s2;
   logic        trig_d;
   logic        trig;
   logic        trig_fall;
   logic        trig_rise;
   logic        exp_on;
   logic [23:0] exp_cnt;
   logic        exp_go;
   logic        exp_done;
   logic        exp_hold;
   logic        rd_go;
   logic        rd_busy;
   logic        rd_done;
   logic [31:0] rd_left;
   logic [12:0] rd_col;
   logic [11:0] rd_row;
   logic [12:0] line_last;
   logic [15:0] fcnt;
   logic        wr;
   logic        arm_cmd;
   logic        stop_cmd;
   logic        addr_hit;
   logic [31:0] rd_mux;

   // Full readout period: lines of pixels plus blanking
   function automatic logic [31:0] frame_len(input logic [11:0] p, input logic [11:0] l);
      logic [31:0] per_line;
      per_line  = 32'(p) + 32'(LGAP);
      frame_len = 32'(per_line * 32'(l)) + FGAP;
   endfunction

   // Bus decode
   assign wr       = I_PSEL && I_PENABLE && I_PWRITE;
   assign addr_hit = (I_PADDR == ets_pkg::A_CTRL) || (I_PADDR == ets_pkg::A_EXPO) ||
                     (I_PADDR == ets_pkg::A_GEOM) || (I_PADDR == ets_pkg::A_STAT);
   assign arm_cmd  = wr && (I_PADDR == ets_pkg::A_CTRL) && I_PWDATA[ets_pkg::CTRL_ARM];
   assign stop_cmd = wr && (I_PADDR == ets_pkg::A_CTRL) && I_PWDATA[ets_pkg::CTRL_STOP];
   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = I_PSEL && I_PENABLE && !addr_hit;

   // Register writes
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         mode_reg  <= ets_pkg::M_OVL_SHUT;
         flash_en  <= 1'b0;
         gpo_sel   <= 1'b0;
         gpo_level <= 1'b0;
         expo      <= ets_pkg::EXPO_RST;
         pix       <= ets_pkg::PIX_RST;
         lines     <= ets_pkg::LIN_RST;
      end else if (wr) begin
         case (I_PADDR)
            ets_pkg::A_CTRL: begin
               mode_reg  <= ets_pkg::ets_mode_e'(I_PWDATA[ets_pkg::CTRL_MODE_LSB +: 3]);
               flash_en  <= I_PWDATA[ets_pkg::CTRL_FLASH];
               gpo_sel   <= I_PWDATA[ets_pkg::CTRL_GPO_SEL];
               gpo_level <= I_PWDATA[ets_pkg::CTRL_GPO_LVL];
            end
            ets_pkg::A_EXPO: expo <= I_PWDATA[23:0];
            ets_pkg::A_GEOM: begin
               pix   <= I_PWDATA[ets_pkg::GEOM_PIX_LSB +: 12];
               lines <= I_PWDATA[ets_pkg::GEOM_LIN_LSB +: 12];
            end
            default: ;
         endcase
      end
   end

   // Read data mux
   always_comb begin
      rd_mux = 32'h0;
      case (I_PADDR)
         ets_pkg::A_CTRL: begin
            rd_mux[ets_pkg::CTRL_MODE_LSB +: 3] = mode_reg;
            rd_mux[ets_pkg::CTRL_FLASH]   = flash_en;
            rd_mux[ets_pkg::CTRL_GPO_SEL] = gpo_sel;
            rd_mux[ets_pkg::CTRL_GPO_LVL] = gpo_level;
         end
         ets_pkg::A_EXPO: rd_mux[23:0] = expo;
         ets_pkg::A_GEOM: begin
            rd_mux[ets_pkg::GEOM_PIX_LSB +: 12] = pix;
            rd_mux[ets_pkg::GEOM_LIN_LSB +: 12] = lines;
         end
         ets_pkg::A_STAT: begin
            rd_mux[ets_pkg::STAT_ST_LSB +: 3] = state;
            rd_mux[ets_pkg::STAT_EXP]         = exp_on;
            rd_mux[ets_pkg::STAT_RD]          = rd_busy;
            rd_mux[ets_pkg::STAT_FC_LSB +: 16] = fcnt;
         end
         default: rd_mux = 32'h0;
      endcase
   end

   // Read data captured in the setup phase
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         O_PRDATA <= 32'h0;
      end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
         O_PRDATA <= rd_mux;
      end
   end

   // Trigger synchronisers, merge and edge detect
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         cc1_s1 <= 1'b1;
         cc1_s2 <= 1'b1;
         ext_s1 <= 1'b1;
         ext_s2 <= 1'b1;
         trig_d <= 1'b1;
         O_TRIGGER_ECHO_OUT <= 1'b1;
      end else begin
         cc1_s1 <= I_CC1_TRIG_N;
         cc1_s2 <= cc1_s1;
         ext_s1 <= I_EXT_TRIG_N;
         ext_s2 <= ext_s1;
         trig_d <= trig;
         O_TRIGGER_ECHO_OUT <= cc1_s2;
      end
   end
   assign trig      = cc1_s2 & ext_s2;
   assign trig_fall = trig_d & ~trig;
   assign trig_rise = ~trig_d & trig;

   // Exposure end conditions
   assign exp_hold = (state == ets_pkg::S_RUN) && (run_mode == ets_pkg::M_OVL_EXT) &&
                     rd_busy && !rd_done;
   assign exp_done = exp_on && (exp_cnt <= 24'h1) && !exp_hold &&
                     (run_mode != ets_pkg::M_BULB);
   assign rd_done  = rd_busy && (rd_left == 32'h1);

   // Sequencer next state and start strobes
   always_comb begin
      next_state = state;
      exp_go     = 1'b0;
      rd_go      = 1'b0;
      case (state)
         ets_pkg::S_IDLE: if (arm_cmd) next_state = ets_pkg::S_ARMED;
         ets_pkg::S_ARMED: if (trig_fall) begin
            exp_go     = 1'b1;
            next_state = ets_pkg::S_EXPOSE;
         end
         ets_pkg::S_EXPOSE: begin
            if (run_mode == ets_pkg::M_BULB) begin
               if (trig_rise) begin
                  rd_go      = 1'b1;
                  next_state = ets_pkg::S_READ;
               end
            end else if (exp_done) begin
               rd_go = 1'b1;
               if (run_mode == ets_pkg::M_OVL_SHUT || run_mode == ets_pkg::M_OVL_EXT) begin
                  next_state = ets_pkg::S_RUN;
                  exp_go     = (run_mode == ets_pkg::M_OVL_EXT);
               end else begin
                  next_state = ets_pkg::S_READ;
               end
            end
         end
         ets_pkg::S_READ: if (rd_done) begin
            if (run_mode == ets_pkg::M_NONOVL) begin
               exp_go     = 1'b1;
               next_state = ets_pkg::S_EXPOSE;
            end else begin
               next_state = ets_pkg::S_ARMED;
            end
         end
         ets_pkg::S_RUN: begin
            if (run_mode == ets_pkg::M_OVL_SHUT) begin
               if (rd_busy && rd_left == {8'h0, expo}) exp_go = 1'b1;
               if (rd_done) rd_go = 1'b1;
            end else if (exp_done) begin
               exp_go = 1'b1;
               rd_go  = 1'b1;
            end
         end
         default: next_state = ets_pkg::S_IDLE;
      endcase
      if (stop_cmd && state != ets_pkg::S_IDLE) begin
         next_state = ets_pkg::S_IDLE;
         exp_go     = 1'b0;
         rd_go      = 1'b0;
      end
   end

   // State register and mode latched at arm
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         state    <= ets_pkg::S_IDLE;
         run_mode <= ets_pkg::M_OVL_SHUT;
      end else begin
         state <= next_state;
         // Mode taken from the arming write itself, not the stale register
         if (state == ets_pkg::S_IDLE && arm_cmd) begin
            run_mode <= ets_pkg::ets_mode_e'(I_PWDATA[ets_pkg::CTRL_MODE_LSB +: 3]);
         end
      end
   end

   // Exposure timer
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         exp_on  <= 1'b0;
         exp_cnt <= 24'h0;
      end else if (exp_go) begin
         exp_on  <= 1'b1;
         exp_cnt <= expo;
      end else if (stop_cmd) begin
         exp_on <= 1'b0;
      end else if (exp_on && run_mode == ets_pkg::M_BULB) begin
         if (trig_rise) exp_on <= 1'b0;
      end else if (exp_done) begin
         exp_on <= 1'b0;
      end else if (exp_on && exp_cnt > 24'h1) begin
         exp_cnt <= exp_cnt - 24'h1;
      end
   end

   // Readout timing counters
   assign line_last = {1'b0, pix} + LGAP - 13'h1;
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         rd_busy <= 1'b0;
         rd_left <= 32'h0;
         rd_col  <= 13'h0;
         rd_row  <= 12'h0;
      end else if (rd_go) begin
         rd_busy <= 1'b1;
         rd_left <= frame_len(pix, lines);
         rd_col  <= 13'h0;
         rd_row  <= 12'h0;
      end else if (rd_busy) begin
         rd_left <= rd_left - 32'h1;
         if (rd_done) rd_busy <= 1'b0;
         if (rd_col >= line_last) begin
            rd_col <= 13'h0;
            if (rd_row != lines) rd_row <= rd_row + 12'h1;
         end else begin
            rd_col <= rd_col + 13'h1;
         end
      end
   end

   // Completed frame counter
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         fcnt <= 16'h0;
      end else if (rd_done) begin
         fcnt <= fcnt + 16'h1;
      end
   end

   // Line and frame qualifiers
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         O_LINE_VALID_OUT  <= 1'b0;
         O_FRAME_VALID_OUT <= 1'b0;
      end else begin
         O_LINE_VALID_OUT  <= rd_busy && (rd_row < lines) && (rd_col < {1'b0, pix});
         O_FRAME_VALID_OUT <= rd_busy && (rd_row < lines) &&
            !((rd_row == lines - 12'h1) && (rd_col >= {1'b0, pix}));
      end
   end

   // Flash sync: exposure window or host level
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         O_FLASH_SYNC <= 1'b0;
      end else if (gpo_sel) begin
         O_FLASH_SYNC <= gpo_level;
      end else begin
         O_FLASH_SYNC <= flash_en && exp_on && (run_mode != ets_pkg::M_OVL_EXT);
      end
   end

   property p_arm_start;
      @(posedge I_MCLK) disable iff (I_RST)
      (state == ets_pkg::S_ARMED && trig_fall && !stop_cmd) |=> exp_on;
   endproperty
   a_arm_start: assert property (p_arm_start) else $error("no exposure on trigger");

   property p_run_holds;
      @(posedge I_MCLK) disable iff (I_RST)
      (state == ets_pkg::S_RUN && !stop_cmd) |=> (state == ets_pkg::S_RUN);
   endproperty
   a_run_holds: assert property (p_run_holds) else $error("run left without stop");

   property p_stop;
      @(posedge I_MCLK) disable iff (I_RST)
      (stop_cmd && state != ets_pkg::S_IDLE) |=> (state == ets_pkg::S_IDLE && !exp_on);
   endproperty
   a_stop: assert property (p_stop) else $error("stop not honoured");

   property p_ext_dark;
      @(posedge I_MCLK) disable iff (I_RST)
      (run_mode == ets_pkg::M_OVL_EXT && !gpo_sel) |=> !O_FLASH_SYNC;
   endproperty
   a_ext_dark: assert property (p_ext_dark) else $error("flash in extended mode");

   property p_serial;
      @(posedge I_MCLK) disable iff (I_RST)
      (state == ets_pkg::S_READ) |-> !exp_on;
   endproperty
   a_serial: assert property (p_serial) else $error("exposure during readout");

   property p_bulb_end;
      @(posedge I_MCLK) disable iff (I_RST)
      (state == ets_pkg::S_EXPOSE && run_mode == ets_pkg::M_BULB && trig_rise && !stop_cmd)
      |=> (rd_busy && !exp_on && state == ets_pkg::S_READ);
   endproperty
   a_bulb_end: assert property (p_bulb_end) else $error("bulb end missed");

   property p_bulb_read;
      @(posedge I_MCLK) disable iff (I_RST)
      (state == ets_pkg::S_READ && run_mode == ets_pkg::M_BULB && !rd_done && !stop_cmd)
      |=> (state == ets_pkg::S_READ);
   endproperty
   a_bulb_read: assert property (p_bulb_read) else $error("bulb readout disturbed");

   property p_line_in_frame;
      @(posedge I_MCLK) disable iff (I_RST)
      O_LINE_VALID_OUT |-> O_FRAME_VALID_OUT;
   endproperty
   a_line_in_frame: assert property (p_line_in_frame) else $error("line outside frame");

   property p_frame_end;
      @(posedge I_MCLK) disable iff (I_RST)
      $fell(O_FRAME_VALID_OUT) |-> $fell(O_LINE_VALID_OUT);
   endproperty
   a_frame_end: assert property (p_frame_end) else $error("frame ends inside line");

   property p_gpo;
      @(posedge I_MCLK) disable iff (I_RST)
      gpo_sel |=> (O_FLASH_SYNC == $past(gpo_level));
   endproperty
   a_gpo: assert property (p_gpo) else $error("host level not driven");
endmodule // ets_top

// file: verif/ets_host_model.sv
// Frame grabber and trigger source model facing the sequencer
module ets_host_model (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_lv,
   input  wire logic i_fv,
   input  wire logic i_flash,
   output logic      o_cc1_n,
   output logic      o_ext_n,
   output int        o_lines,
   output int        o_frames,
   output int        o_flash_len,
   output int        o_flash_hi,
   output int        o_period,
   output int        o_stray
);
   timeunit 1ns;
   timeprecision 1ps;
   logic lv_d;
   logic fv_d;
   logic fl_d;
   int   gap;
   int   run;

   // Trigger lines rest high through their pull-ups
   initial begin
      o_cc1_n = 1'b1;
      o_ext_n = 1'b1;
   end

   // One active-low pulse of w clocks on the host or external line
   task automatic pulse(input bit use_ext, input int w);
      if (use_ext) begin
         o_ext_n <= 1'b0;
      end else begin
         o_cc1_n <= 1'b0;
      end
      repeat (w) @(posedge i_clk);
      o_cc1_n <= 1'b1;
      o_ext_n <= 1'b1;
   endtask

   // Count lines, frames, frame spacing and flash pulses as a grabber would
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         {lv_d, fv_d, fl_d} <= 3'h0;
         {o_lines, o_frames, o_flash_len, o_flash_hi, o_period, o_stray} <= '0;
         gap <= 0;
         run <= 0;
      end else begin
         lv_d <= i_lv;
         fv_d <= i_fv;
         fl_d <= i_flash;
         gap  <= gap + 1;
         if (i_lv && !lv_d) o_lines <= o_lines + 1;
         if (i_fv && !fv_d) begin
            o_frames <= o_frames + 1;
            o_period <= gap;
            gap      <= 1;
         end
         if (i_flash) begin
            run        <= fl_d ? run + 1 : 1;
            o_flash_hi <= o_flash_hi + 1;
         end
         if (!i_flash && fl_d) o_flash_len <= run;
         if (i_lv && !i_fv) o_stray <= o_stray + 1; // Line outside a frame
      end
   end
endmodule // ets_host_model

// file: verif/ets_top_tb.sv
// Self-checking bench of the exposure trigger sequencer
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
   $display("Error %0t: got %0h expected %0h", $time, (got), (exp)); end end
module ets_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LG  = 2;
   localparam int FG  = 4;
   localparam int LIN = 3;
   localparam int RD  = LIN * (4 + LG) + FG;
   localparam logic [31:0] ARM_FL = 32'h00000108; // Arm plus flash enable
   typedef struct {
      ets_pkg::ets_mode_e mode;
      logic [31:0]        expo;
      bit                 cont;
      bit                 fl_on;
      int                 width;
      int                 per;
   } ets_row_s;
   ets_row_s rows [5] = '{
      '{ets_pkg::M_OVL_SHUT, 32'h0000000a, 1'b1, 1'b1, 10, RD},
      '{ets_pkg::M_OVL_EXT,  32'h00000028, 1'b1, 1'b0, 3,  40},
      '{ets_pkg::M_NONOVL,   32'h0000000a, 1'b1, 1'b1, 10, 10 + RD},
      '{ets_pkg::M_SINGLE,   32'h0000000a, 1'b0, 1'b1, 10, 0},
      '{ets_pkg::M_BULB,     32'h00000004, 1'b0, 1'b1, 12, 0}};
   logic        mclk, rst, psel, penable, pwrite, pready, pslverr, rerr;
   logic        lv, fv, flash, echo, cc1_n, ext_n;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   int          lines, frames, flash_len, flash_hi, period, stray;
   int          err_total, cmp_count, f0, h0, l0, f1;

   // Free-running 50 MHz clock
   always #10 mclk = ~mclk;

   ets_top #(.LINE_GAP(LG), .FRAME_GAP(FG)) i_ets_top (
      .I_MCLK(mclk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .I_CC1_TRIG_N(cc1_n), .I_EXT_TRIG_N(ext_n),
      .O_LINE_VALID_OUT(lv), .O_FRAME_VALID_OUT(fv), .O_FLASH_SYNC(flash),
      .O_TRIGGER_ECHO_OUT(echo));

   ets_host_model i_ets_host_model (
      .i_clk(mclk), .i_rst(rst), .i_lv(lv), .i_fv(fv), .i_flash(flash), .o_cc1_n(cc1_n),
      .o_ext_n(ext_n), .o_lines(lines), .o_frames(frames), .o_flash_len(flash_len),
      .o_flash_hi(flash_hi), .o_period(period), .o_stray(stray));

   // Verdict and end of run
   task automatic results;
      $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // A wait that ran out of cycles
   task automatic stall;
      err_total++;
      $display("Error %0t: wait timed out", $time);
      results();
   endtask

   // One APB transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) stall();
      @(posedge mclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   task automatic wait_frames(input int n);
      for (int k = 0; k < 3000 && frames < n; k++) @(posedge mclk);
      if (frames < n) stall();
   endtask

   task automatic wait_state(input logic [2:0] s);
      for (int k = 0; k < 300; k++) begin
         rd(ets_pkg::A_STAT);
         if (rdat[2:0] === s) return;
      end
      stall();
   endtask

   // Main sequence
   initial begin
      {mclk, psel, penable, pwrite, paddr, pwdata} = '0;
      {err_total, cmp_count} = '0;
      rst = 1'b1;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1;
      `CHK({echo, lv, fv, flash}, 4'h8)
      @(posedge mclk);
      rd(ets_pkg::A_EXPO);
      `CHK(rdat, {8'h0, ets_pkg::EXPO_RST})
      rd(12'h010);
      `CHK({rerr, rdat}, {1'b1, 32'h0})
      fork
         i_ets_host_model.pulse(1'b0, 8);
         begin
            repeat (5) @(posedge mclk);
            #1;
            `CHK(echo, 1'b0)
         end
      join
      @(posedge mclk);
      fork
         i_ets_host_model.pulse(1'b1, 8);
         begin
            repeat (5) @(posedge mclk);
            #1;
            `CHK(echo, 1'b1)
         end
      join
      @(posedge mclk);
      wr(ets_pkg::A_CTRL, 32'h00000030);
      @(posedge mclk);
      `CHK(flash, 1'b1)
      wr(ets_pkg::A_CTRL, 32'h00000010);
      @(posedge mclk);
      `CHK(flash, 1'b0)
      wr(ets_pkg::A_GEOM, 32'h00030004);
      // Table of modes: arm, trigger, run, stop
      for (int r = 0; r < 5; r++) begin
         f0 = frames;
         h0 = flash_hi;
         l0 = lines;
         wr(ets_pkg::A_EXPO, rows[r].expo);
         wr(ets_pkg::A_CTRL, ARM_FL | 32'(rows[r].mode));
         rd(ets_pkg::A_STAT);
         `CHK(rdat[2:0], ets_pkg::S_ARMED)
         i_ets_host_model.pulse(r[0], rows[r].mode == ets_pkg::M_BULB ? rows[r].width : 3);
         wait_frames(f0 + 1);
         if (rows[r].cont) begin
            i_ets_host_model.pulse(!r[0], 3);
            wait_frames(f0 + 3);
            `CHK(period >= rows[r].per, 1'b1)
         end else begin
            wait_state(ets_pkg::S_ARMED);
            repeat (4) @(posedge mclk);
            `CHK(frames - f0, 1)
         end
         if (rows[r].fl_on) begin
            `CHK(flash_len, rows[r].width)
         end else begin
            `CHK(flash_hi - h0, 0)
         end
         if (rows[r].mode == ets_pkg::M_OVL_SHUT) begin
            `CHK(period, RD)
            wr(ets_pkg::A_EXPO, 32'h00000005);
            wait_frames(frames + 2);
            repeat (4) @(posedge mclk);
            `CHK({period, flash_len}, {RD, 32'd5})
         end
         wr(ets_pkg::A_CTRL, 32'h00000200);
         wait_state(ets_pkg::S_IDLE);
         f1 = frames;
         repeat (60) @(posedge mclk);
         `CHK(frames, f1)
         `CHK(lines - l0, LIN * (frames - f0))
         `CHK(stray, 0)
      end
      // Bulb trigger during readout must change nothing
      f0 = frames;
      wr(ets_pkg::A_CTRL, ARM_FL | 32'(ets_pkg::M_BULB));
      i_ets_host_model.pulse(1'b0, 12);
      wait_state(ets_pkg::S_READ);
      i_ets_host_model.pulse(1'b1, 3);
      wait_state(ets_pkg::S_ARMED);
      repeat (40) @(posedge mclk);
      `CHK(frames - f0, 1)
      rd(ets_pkg::A_STAT);
      `CHK(rdat[2:0], ets_pkg::S_ARMED)
      // Reset in the middle of a readout
      i_ets_host_model.pulse(1'b0, 8);
      repeat (8) @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      `CHK({lv, fv, flash}, 3'h0)
      @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd(ets_pkg::A_STAT);
      `CHK(rdat[2:0], ets_pkg::S_IDLE)
      results();
   end
endmodule // ets_top_tb
